/* File: src/rmsd_defs.vh */
// Constants for the render mode subcommand decoder.
// Assumes inclusion by the decoder module only; definitions only.
`ifndef RMSD_DEFS_VH
`define RMSD_DEFS_VH

// ------------------------------------------------------------
// Command codes
// ------------------------------------------------------------
`define RMSD_CMD_INIT      4'hf
`define RMSD_CMD_SELECT    4'he
`define RMSD_CMD_ARGUMENT  4'hd

// ------------------------------------------------------------
// Subcommand numbers
// ------------------------------------------------------------
`define RMSD_SUB_SHADE     16'h0000
`define RMSD_SUB_LINE      16'h0001
`define RMSD_SUB_XFER      16'h0002
`define RMSD_SUB_DEPTH     16'h0003
`define RMSD_SUB_HW        16'h0004
`define RMSD_SUB_MASK      16'h0005
`define RMSD_SUB_NONE      16'hffff

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define RMSD_DC_CUT_SRC    4
`define RMSD_DC_CUT_EN     5
`define RMSD_DC_HIDDEN     6
`define RMSD_HC_FIXUP      13
`define RMSD_HC_LOCKSTEP   11
`define RMSD_HC_COMBINED   10
`define RMSD_HC_SHORTCAS   8
`define RMSD_HC_BITMASK    7
`define RMSD_HC_UPLOAD     3
`define RMSD_HC_INTENSITY  2
`define RMSD_HC_DEPTH      1
`define RMSD_HC_CUTDATA    0

// ------------------------------------------------------------
// Mode values and reset values
// ------------------------------------------------------------
`define RMSD_SHADE_GOURAUD 2'h0
`define RMSD_SHADE_FLAT    2'h1
`define RMSD_LINE_FGBG     2'h0
`define RMSD_LINE_FGONLY   2'h1
`define RMSD_LINE_3D       2'h2
`define RMSD_RST_SHADE     2'h0
`define RMSD_RST_LINE      2'h1
`define RMSD_RST_XFER      1'h0
`define RMSD_RST_DEPTH     3'h0
`define RMSD_RST_HW        16'h0000
`define RMSD_RST_MASK      16'hffff

// ------------------------------------------------------------
// Timing counts in clock periods
// ------------------------------------------------------------
`define RMSD_CAS_LONG      3'h4
`define RMSD_CAS_SHORT     3'h2

`endif

/* File: src/rmsd_decoder.v */
// Subcommand select/argument decoder holding the rendering mode state.
// Assumes host writes arrive synchronous to clk_sys as a one-cycle strobe.
// Pixel requests come from the drawing engine on the same clock.
// Outputs are levels for the drawing datapath and VRAM cycle generator.
//
// Functional notes
// R1: Select first, then arguments apply to it
// R2: Code E selects, code D carries argument
// R3: Subcommands 0..5 decode to six mode registers
// R4: Shading 0 interpolated, 1 constant
// R5: Line mode 0 writes foreground and background
// R6: Line mode 1 writes foreground pixels only
// R7: Line mode 2 interpolates, ignores dash mask
// R8: Transfer format 0 16-bit, 1 sixteen 1-bit
// R9: Host keeps 16-bit format in paired use
// R10: Depth bit 4 picks cut source
// R11: Depth bit 5 enables depth cutting
// R12: Depth bit 6 enables hidden surface test
// R13: Hardware bit 13 subpixel fixup, else rounding
// R14: Hardware bit 11 enables lockstep input
// R15: Hardware bit 10 combined VRAM cycles
// R16: Hardware bit 8 shortens CAS cycle 4->2; code shortens it only under flat shading
// R17: Hardware bit 7 gates bitmask write strobe; code also requires transfer format 1
// R18: Hardware bit 3 picks transfer buffer
// R19: Hardware bit 2 gates intensity write strobe
// R20: Hardware bit 1 gates depth write strobe
// R21: Hardware bit 0 gates cut data strobe; code also requires depth cutting enabled
// R22: Pixel enable ANDed with mask bit 4Y+X
// R23: Mask bypassed for interpolated shading, 3D lines
// R24: Mask holds until init or rewrite
// R25: Init restores all mode defaults
`timescale 1ns/1ps
`include "rmsd_defs.vh"

module rmsd_decoder (
  clk_sys,
  resetn,
  host_wr,
  host_cmd,
  host_data,
  draw_polygon,
  pix_x_lsb,
  pix_y_lsb,
  pix_pattern_bit,
  pix_req,
  shading_mode_select,
  line_style_select,
  transfer_pixel_format,
  cut_source_select,
  cut_enable,
  hidden_surface_enable,
  depth_interpolate,
  dash_mask_apply,
  subpixel_fixup,
  external_lockstep_enable,
  combined_vram_cycle,
  short_cas_cycle,
  cas_cycle_periods,
  bitmask_write_strobe,
  upload_buffer_select,
  intensity_write_strobe,
  depth_write_strobe,
  cut_data_write_strobe,
  see_through_mask,
  pix_write,
  pix_use_foreground
);
  input         clk_sys;
  input         resetn;
  input         host_wr;
  input  [3:0]  host_cmd;
  input  [15:0] host_data;
  input         draw_polygon;
  input  [1:0]  pix_x_lsb;
  input  [1:0]  pix_y_lsb;
  input         pix_pattern_bit;
  input         pix_req;
  output [1:0]  shading_mode_select;
  output [1:0]  line_style_select;
  output        transfer_pixel_format;
  output        cut_source_select;
  output        cut_enable;
  output        hidden_surface_enable;
  output        depth_interpolate;
  output        dash_mask_apply;
  output        subpixel_fixup;
  output        external_lockstep_enable;
  output        combined_vram_cycle;
  output        short_cas_cycle;
  output [2:0]  cas_cycle_periods;
  output        bitmask_write_strobe;
  output        upload_buffer_select;
  output        intensity_write_strobe;
  output        depth_write_strobe;
  output        cut_data_write_strobe;
  output [15:0] see_through_mask;
  output        pix_write;
  output        pix_use_foreground;

  // Limitations: reserved mode values are stored as written, and the
  // engine must treat them as the safe case. A select number above five
  // leaves every register alone until a new select or an init arrives. Only one
  // selection is held, so a second host must not interleave its own
  // select and argument pairs with ours. Pixel requests are taken at
  // most one per cycle; each result stands for exactly one cycle.

  // ----------------------------------------------------------
  // Mode state
  // ----------------------------------------------------------
  // Selection and stored modes
  reg [15:0] subcmd_r;
  reg [15:0] subcmd_nxt;
  reg [1:0]  shade_r;
  reg [1:0]  shade_nxt;
  reg [1:0]  line_r;
  reg [1:0]  line_nxt;
  reg        xfer_r;
  reg        xfer_nxt;
  reg [2:0]  depth_r;
  reg [2:0]  depth_nxt;
  reg [15:0] hw_r;
  reg [15:0] hw_nxt;
  reg [15:0] mask_r;
  reg [15:0] mask_nxt;

  // Pixel result flops
  reg        pix_write_r;
  reg        pix_write_nxt;
  reg        pix_fg_r;
  reg        pix_fg_nxt;

  // Command strobes, mask lookup and bypass
  wire       wr_select;
  wire       wr_argument;
  wire       wr_init;
  wire [3:0] mask_index;
  wire       mask_bypass;
  wire [1:0] arg_shade;
  wire [1:0] arg_line;
  wire       arg_xfer;
  wire [2:0] arg_depth;

  wire       sel_shade;
  wire       sel_line;
  wire       sel_xfer;
  wire       sel_depth;
  wire       sel_hw;
  wire       sel_mask;

  // Derived levels get flops of their own
  reg        depth_interp_r;
  reg        depth_interp_nxt;
  reg        dash_apply_r;
  reg        dash_apply_nxt;
  reg        short_cas_r;
  reg        short_cas_nxt;
  reg [2:0]  cas_periods_r;
  reg [2:0]  cas_periods_nxt;
  reg        bitmask_r;
  reg        bitmask_nxt;
  reg        cut_data_r;
  reg        cut_data_nxt;

  // Strobes for the three codes this block owns; every other
  // code belongs to the drawing engine and is ignored here
  assign wr_select   = host_wr && (host_cmd == `RMSD_CMD_SELECT);   // see R2
  assign wr_argument = host_wr && (host_cmd == `RMSD_CMD_ARGUMENT); // see R2
  assign wr_init     = host_wr && (host_cmd == `RMSD_CMD_INIT);

  // Argument fields; spare bits of the word are dropped, not checked
  assign arg_shade = host_data[1:0];                                // see R4
  assign arg_line  = host_data[1:0];                                // see R5 R6 R7
  assign arg_xfer  = host_data[0];                                  // see R8
  assign arg_depth = {host_data[`RMSD_DC_HIDDEN], host_data[`RMSD_DC_CUT_EN],
                      host_data[`RMSD_DC_CUT_SRC]};                 // see R10 R11 R12

  // ----------------------------------------------------------
  // Selected subcommand
  // ----------------------------------------------------------
  // Full sixteen-bit compare, so a stray high bit selects nothing
  assign sel_shade = (subcmd_r == `RMSD_SUB_SHADE);                 // see R3
  assign sel_line  = (subcmd_r == `RMSD_SUB_LINE);                  // see R3
  assign sel_xfer  = (subcmd_r == `RMSD_SUB_XFER);                  // see R3
  assign sel_depth = (subcmd_r == `RMSD_SUB_DEPTH);                 // see R3
  assign sel_hw    = (subcmd_r == `RMSD_SUB_HW);                    // see R3
  assign sel_mask  = (subcmd_r == `RMSD_SUB_MASK);                  // see R3

  // ----------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------
  // Two-step protocol: a select stores the subcommand number, then every
  // argument lands in the register it names. The selection persists, so
  // several arguments may follow one select, each overwriting the last.
  // Init restores defaults and drops the selection in the same cycle.
  always @* begin
    subcmd_nxt = subcmd_r;
    shade_nxt  = shade_r;
    line_nxt   = line_r;
    xfer_nxt   = xfer_r;
    depth_nxt  = depth_r;
    hw_nxt     = hw_r;
    mask_nxt   = mask_r;
    if (wr_init) begin
      // Defaults; selection dropped so stray arguments do nothing
      subcmd_nxt = `RMSD_SUB_NONE;
      shade_nxt  = `RMSD_RST_SHADE;          // see R25
      line_nxt   = `RMSD_RST_LINE;
      xfer_nxt   = `RMSD_RST_XFER;
      depth_nxt  = `RMSD_RST_DEPTH;
      hw_nxt     = `RMSD_RST_HW;
      mask_nxt   = `RMSD_RST_MASK;           // see R24
    end else if (wr_select) begin
      subcmd_nxt = host_data;                // see R1
    end else if (wr_argument) begin
      // Unknown or unselected numbers are ignored, see R3
      if (sel_shade) begin
        // Reserved shading values are kept; the host must not send them
        shade_nxt = arg_shade;               // see R4
      end else if (sel_line) begin
        // Reserved line values turn every line pixel off
        line_nxt = arg_line;                 // see R5 R6 R7
      end else if (sel_xfer) begin
        // Only addressing changes; pixel steering is outside
        xfer_nxt = arg_xfer;                 // see R8
      end else if (sel_depth) begin
        // Three control bits packed as hidden, cut enable, cut source
        depth_nxt = arg_depth;               // see R10 R11 R12
      end else if (sel_hw) begin
        // Whole word kept; spare bits are stored but unused
        hw_nxt = host_data;                  // see R13 R14 R15
      end else if (sel_mask) begin
        // Bit 4Y+X enables the pixel at that position of the 4x4 tile
        mask_nxt = host_data;                // see R24
      end
    end
  end

  // ----------------------------------------------------------
  // Per-pixel write gating
  // ----------------------------------------------------------
  assign mask_index  = {pix_y_lsb, pix_x_lsb};                     // see R22
  // Interpolated polygons and 3D lines see through nothing
  assign mask_bypass = draw_polygon ? (shade_r == `RMSD_SHADE_GOURAUD)
                                    : (line_r == `RMSD_LINE_3D);   // see R23

  // Result is registered one cycle after the request. Mode gating picks
  // which pixels the line or polygon wants, then the see-through mask
  // removes, unless bypassed, any whose tile bit is clear. The mask lookup is a plain
  // sixteen-way select, cheap enough that no pipelining is needed.
  always @* begin
    pix_write_nxt = 1'b0;
    pix_fg_nxt    = 1'b1;
    if (pix_req) begin
      if (draw_polygon) begin
        // Polygons want every pixel; only the mask may drop one
        pix_write_nxt = 1'b1;
      end else if (line_r == `RMSD_LINE_FGBG) begin
        pix_write_nxt = 1'b1;                // see R5
        pix_fg_nxt    = pix_pattern_bit;
      end else if (line_r == `RMSD_LINE_FGONLY) begin
        pix_write_nxt = pix_pattern_bit;     // see R6
      end else if (line_r == `RMSD_LINE_3D) begin
        pix_write_nxt = 1'b1;                // see R7
      end
      // Reserved line modes write nothing
      if (!mask_bypass && !mask_r[mask_index]) begin
        pix_write_nxt = 1'b0;                // see R22
      end
    end
  end

  // ----------------------------------------------------------
  // Derived mode levels
  // ----------------------------------------------------------
  // Worked out from next state so they move on the same edge as the
  // modes; a cycle of lag would hand the engine a stale mix of settings.
  always @* begin
    // Depth follows endpoints only on 3D lines with the test on
    depth_interp_nxt = (line_nxt == `RMSD_LINE_3D) && depth_nxt[2];      // see R7
    // The dash mask means nothing once intensity is interpolated
    dash_apply_nxt   = (line_nxt != `RMSD_LINE_3D);                      // see R7
    // Short CAS only under constant shading; page mode is the cycler's call
    short_cas_nxt    = hw_nxt[`RMSD_HC_SHORTCAS] &&
                       (shade_nxt == `RMSD_SHADE_FLAT);                  // see R16
    cas_periods_nxt  = `RMSD_CAS_LONG;                                   // see R16
    if (short_cas_nxt) begin
      cas_periods_nxt = `RMSD_CAS_SHORT;                                 // see R16
    end
    // Bitmask strobe only means something in the 1-bit format
    bitmask_nxt      = hw_nxt[`RMSD_HC_BITMASK] && xfer_nxt;             // see R17
    // Cut data strobe is dead while cutting is off
    cut_data_nxt     = hw_nxt[`RMSD_HC_CUTDATA] && depth_nxt[1];         // see R21
  end

  // ----------------------------------------------------------
  // Registers
  // ----------------------------------------------------------
  // Mode state; reset and init land on the same defaults
  always @(posedge clk_sys) begin
    if (!resetn) begin
      subcmd_r    <= `RMSD_SUB_NONE;
      shade_r     <= `RMSD_RST_SHADE;
      line_r      <= `RMSD_RST_LINE;
      xfer_r      <= `RMSD_RST_XFER;
      depth_r     <= `RMSD_RST_DEPTH;
      hw_r        <= `RMSD_RST_HW;
      mask_r      <= `RMSD_RST_MASK;
    end else begin
      subcmd_r    <= subcmd_nxt;
      shade_r     <= shade_nxt;
      line_r      <= line_nxt;
      xfer_r      <= xfer_nxt;
      depth_r     <= depth_nxt;
      hw_r        <= hw_nxt;
      mask_r      <= mask_nxt;
    end
  end

  // Pixel results and derived levels
  always @(posedge clk_sys) begin
    if (!resetn) begin
      pix_write_r    <= 1'b0;
      pix_fg_r       <= 1'b1;
      depth_interp_r <= 1'b0;
      dash_apply_r   <= 1'b1;
      short_cas_r    <= 1'b0;
      cas_periods_r  <= `RMSD_CAS_LONG;
      bitmask_r      <= 1'b0;
      cut_data_r     <= 1'b0;
    end else begin
      pix_write_r    <= pix_write_nxt;
      pix_fg_r       <= pix_fg_nxt;
      depth_interp_r <= depth_interp_nxt;
      dash_apply_r   <= dash_apply_nxt;
      short_cas_r    <= short_cas_nxt;
      cas_periods_r  <= cas_periods_nxt;
      bitmask_r      <= bitmask_nxt;
      cut_data_r     <= cut_data_nxt;
    end
  end

  // ----------------------------------------------------------
  // Mode outputs
  // ----------------------------------------------------------
  // Stored modes straight from their registers
  assign shading_mode_select      = shade_r;                  // see R4
  assign line_style_select        = line_r;                   // see R5 R6 R7
  assign transfer_pixel_format    = xfer_r;                   // see R8
  assign cut_source_select        = depth_r[0];               // see R10
  assign cut_enable               = depth_r[1];               // see R11
  assign hidden_surface_enable    = depth_r[2];               // see R12

  // Derived levels from their own flops
  assign depth_interpolate        = depth_interp_r;           // see R7
  assign dash_mask_apply          = dash_apply_r;             // see R7
  assign short_cas_cycle          = short_cas_r;              // see R16
  assign cas_cycle_periods        = cas_periods_r;            // see R16
  assign bitmask_write_strobe     = bitmask_r;                // see R17
  assign cut_data_write_strobe    = cut_data_r;               // see R21

  // Raw hardware control bits, levels the cycle generator decodes
  assign subpixel_fixup           = hw_r[`RMSD_HC_FIXUP];     // see R13
  assign external_lockstep_enable = hw_r[`RMSD_HC_LOCKSTEP];  // see R14
  assign combined_vram_cycle      = hw_r[`RMSD_HC_COMBINED];  // see R15
  assign upload_buffer_select     = hw_r[`RMSD_HC_UPLOAD];    // see R18
  assign intensity_write_strobe   = hw_r[`RMSD_HC_INTENSITY]; // see R19
  assign depth_write_strobe       = hw_r[`RMSD_HC_DEPTH];     // see R20

  // Pixel results and the mask itself
  assign see_through_mask         = mask_r;                   // see R24
  assign pix_write                = pix_write_r;              // see R22
  assign pix_use_foreground       = pix_fg_r;                 // see R5

endmodule

/* File: verification/rmsd_props.sv */
// Port checks for the render mode subcommand decoder.
// Assumes a bind onto rmsd_decoder; one clock, sync active-low reset.
`timescale 1ns/1ps
module rmsd_props (
  input wire logic        clk_sys,
  input wire logic        resetn,
  input wire logic        host_wr,
  input wire logic [3:0]  host_cmd,
  input wire logic        draw_polygon,
  input wire logic [1:0]  pix_x_lsb,
  input wire logic [1:0]  pix_y_lsb,
  input wire logic        pix_pattern_bit,
  input wire logic        pix_req,
  input wire logic [1:0]  shading_mode_select,
  input wire logic [1:0]  line_style_select,
  input wire logic        hidden_surface_enable,
  input wire logic        depth_interpolate,
  input wire logic        dash_mask_apply,
  input wire logic        short_cas_cycle,
  input wire logic [2:0]  cas_cycle_periods,
  input wire logic [15:0] see_through_mask,
  input wire logic        pix_write
);
  // ----------------------------------------
  // Properties, all gated by reset
  // ----------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  property p_cas; cas_cycle_periods == (short_cas_cycle ? 3'h2 : 3'h4); endproperty
  a_cas: assert property (p_cas) else $error("cas period wrong");
  property p_short; short_cas_cycle |-> shading_mode_select == 2'h1; endproperty
  a_short: assert property (p_short) else $error("short cas w/o flat");
  property p_dash; dash_mask_apply == (line_style_select != 2'h2); endproperty
  a_dash: assert property (p_dash) else $error("dash apply wrong");
  property p_dint; depth_interpolate == (line_style_select == 2'h2 && hidden_surface_enable);
  endproperty
  a_dint: assert property (p_dint) else $error("depth interp wrong");
  // Init must land the mask, shading and line defaults one cycle later
  property p_init; host_wr && host_cmd == 4'hf |=> see_through_mask == 16'hffff &&
    shading_mode_select == 2'h0 && line_style_select == 2'h1; endproperty
  a_init: assert property (p_init) else $error("init defaults");
  // Only argument (D) or init (F) may touch the mask
  property p_hold; !(host_wr && host_cmd[3:2] == 2'h3 && host_cmd[0]) |=> $stable(see_through_mask);
  endproperty
  a_hold: assert property (p_hold) else $error("mask changed");
  property p_fg; pix_req && !draw_polygon && line_style_select == 2'h1 && !pix_pattern_bit
    |=> !pix_write; endproperty
  a_fg: assert property (p_fg) else $error("bg pixel written");
  property p_tmask; pix_req && draw_polygon && shading_mode_select == 2'h1
    |=> pix_write == $past(see_through_mask[{pix_y_lsb, pix_x_lsb}]); endproperty
  a_tmask: assert property (p_tmask) else $error("mask bit gating");
endmodule

/* File: verification/rmsd_host.sv */
// Host model: writes one command per one-cycle strobe.
// Assumes the bench calls its tasks; lines move just after an edge.
`timescale 1ns/1ps
module rmsd_host (
  input wire logic   clk_sys,
  output logic       host_wr,
  output logic [3:0] host_cmd,
  output logic [15:0] host_data
);
  initial begin
    host_wr = 1'b0;
    host_cmd = 4'h0;
    host_data = 16'h0000;
  end
  // Released lines show the inverse, never stale data
  task send(input logic [3:0] c, input logic [15:0] d);
    @(posedge clk_sys) #1;
    host_wr = 1'b1;
    host_cmd = c;
    host_data = d;
    @(posedge clk_sys) #1;
    host_wr = 1'b0;
    host_cmd = ~c;
    host_data = ~d;
  endtask
  // Select first, argument after it; single-device bench, so the
  // paired-generator rule of format 0 never binds here
  task sub(input logic [15:0] s, input logic [15:0] d);
    send(4'he, s);
    send(4'hd, d);
  endtask
endmodule

/* File: verification/test_render_mode_subcommand_decoder.sv */
// Bench for rmsd_decoder: host model plus pixel requests.
// Assumes 10 MHz clock; 16 reset cycles before any command.
`timescale 1ns/1ps
module test_render_mode_subcommand_decoder;
  logic        clk_sys, resetn, draw_polygon, pix_pattern_bit, pix_req, host_wr;
  logic [3:0]  host_cmd;
  logic [15:0] host_data, see_through_mask;
  logic [1:0]  pix_x_lsb, pix_y_lsb, shading_mode_select, line_style_select;
  logic [2:0]  cas_cycle_periods;
  logic        transfer_pixel_format, cut_source_select, cut_enable, hidden_surface_enable;
  logic        depth_interpolate, dash_mask_apply, subpixel_fixup, external_lockstep_enable;
  logic        combined_vram_cycle, short_cas_cycle, bitmask_write_strobe;
  logic        upload_buffer_select, intensity_write_strobe, depth_write_strobe;
  logic        cut_data_write_strobe, pix_write, pix_use_foreground;
  int          n_fail, compares, cyc;
  rmsd_decoder rmsd_decoder_i (.*);
  rmsd_host    rmsd_host_i (.*);
  // ----------------------------------------
  // Clock and cycle ceiling
  // ----------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      end_sim;
    end
  end
  task chk(input logic [15:0] g, input logic [15:0] e);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  // One pixel request; result stands only in the next cycle
  task pix(input logic p, input logic [1:0] x, input logic [1:0] y, input logic b,
           input logic e);
    @(posedge clk_sys) #1;
    {draw_polygon, pix_x_lsb, pix_y_lsb, pix_pattern_bit, pix_req} = {p, x, y, b, 1'b1};
    @(posedge clk_sys) #1;
    pix_req = 1'b0;
    chk(pix_write, e);
  endtask
  task t_reset;
    chk({shading_mode_select, line_style_select, transfer_pixel_format, cut_enable,
         hidden_surface_enable, subpixel_fixup}, 16'h0010);
    chk(see_through_mask, 16'hffff);
    $display("defaults done");
  endtask
  task t_modes;
    for (int i = 0; i < 3; i++) begin
      rmsd_host_i.sub(16'h0001, 16'(i));
      chk(line_style_select, 16'(i));
    end
    for (int i = 0; i < 2; i++) begin
      rmsd_host_i.sub(16'h0000, 16'(i));
      chk(shading_mode_select, 16'(i));
      rmsd_host_i.sub(16'h0002, 16'(i));
      chk(transfer_pixel_format, 16'(i));
    end
    $display("modes done");
  endtask
  // Back-to-back arguments reuse the held selection
  task t_ctrl;
    rmsd_host_i.sub(16'h0003, 16'h0070);
    rmsd_host_i.send(4'hd, 16'h0030);
    chk({cut_source_select, cut_enable, hidden_surface_enable}, 16'h0006);
    rmsd_host_i.sub(16'h0004, 16'h2d8f);
    chk({subpixel_fixup, external_lockstep_enable, combined_vram_cycle, short_cas_cycle,
         bitmask_write_strobe, upload_buffer_select, intensity_write_strobe,
         depth_write_strobe, cut_data_write_strobe, cas_cycle_periods}, 16'h0ffa);
    rmsd_host_i.send(4'hd, 16'h0800);
    chk({subpixel_fixup, external_lockstep_enable, short_cas_cycle, cas_cycle_periods}, 16'h0014);
    $display("controls done");
  endtask
  task t_mask;
    rmsd_host_i.send(4'hf, 16'h0000);
    t_reset;
    rmsd_host_i.send(4'hd, 16'h0002);
    rmsd_host_i.send(4'he, 16'h0006);
    rmsd_host_i.send(4'hd, 16'h0002);
    chk(line_style_select, 16'h0001);
    rmsd_host_i.sub(16'h0005, 16'h0200);
    rmsd_host_i.sub(16'h0000, 16'h0001);
    chk(see_through_mask, 16'h0200);
    pix(1'b1, 2'h1, 2'h2, 1'b0, 1'b1);
    pix(1'b1, 2'h2, 2'h1, 1'b0, 1'b0);
    pix(1'b0, 2'h1, 2'h2, 1'b1, 1'b1);
    pix(1'b0, 2'h2, 2'h1, 1'b1, 1'b0);
    rmsd_host_i.sub(16'h0000, 16'h0000);
    pix(1'b1, 2'h2, 2'h1, 1'b0, 1'b1);
    rmsd_host_i.sub(16'h0001, 16'h0002);
    pix(1'b0, 2'h2, 2'h1, 1'b0, 1'b1);
    rmsd_host_i.send(4'hd, 16'h0003);
    pix(1'b0, 2'h1, 2'h2, 1'b1, 1'b0);
    rmsd_host_i.sub(16'h0005, 16'hffff);
    rmsd_host_i.sub(16'h0001, 16'h0000);
    pix(1'b0, 2'h0, 2'h0, 1'b0, 1'b1);
    chk(pix_use_foreground, 16'h0000);
    rmsd_host_i.send(4'hd, 16'h0001);
    pix(1'b0, 2'h0, 2'h0, 1'b0, 1'b0);
    $display("mask done");
  endtask
  task end_sim;
    $display("compares %0d, mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {resetn, draw_polygon, pix_x_lsb, pix_y_lsb, pix_pattern_bit, pix_req} = '0;
    repeat (16) @(posedge clk_sys);
    #1 resetn = 1'b1;
    t_reset;
    t_modes;
    t_ctrl;
    t_mask;
    end_sim;
  end
endmodule
bind rmsd_decoder rmsd_props rmsd_props_i (.*);
